// File: hdl/nand_mgmt_pkg.sv
/*
 * package for the nand bad-block manager: commands, status bits, geometry, timing.
 * assumes a single 250 MHz clock domain.
 */
package nand_mgmt_pkg;
    localparam int         BLK_W         = 11;
    localparam int         PAGE_W        = 6;
    localparam int         NUM_BLOCKS    = 2048;
    localparam int         MIN_GOOD      = 2008;
    localparam logic [7:0] CMD_READ1     = 8'h00;
    localparam logic [7:0] CMD_READ2     = 8'h30;
    localparam logic [7:0] CMD_PROG1     = 8'h80;
    localparam logic [7:0] CMD_PROG2     = 8'h10;
    localparam logic [7:0] CMD_ERASE1    = 8'h60;
    localparam logic [7:0] CMD_ERASE2    = 8'hd0;
    localparam logic [7:0] CMD_STATUS    = 8'h70;
    localparam logic [7:0] CMD_RESET     = 8'hff;
    localparam logic [7:0] BAD_MARK      = 8'h00;
    localparam int         ST_FAIL_BIT   = 0;
    localparam int         ST_READY_BIT  = 5;
    localparam int         ST_WP_BIT     = 7;
    localparam int         ECC_BITS      = 8;
    localparam int         ECC_SECTOR    = 512;
    localparam int         CLK_NS        = 4;
    localparam int         TWC_NS        = 25;
    localparam int         STROBE_CYC    = (TWC_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [BLK_W-1:0] BLK_RESET = 11'h000;
endpackage

// File: hdl/nand_strobe_div.sv
/*
 * strobe divider: one-cycle enable every STROBE_CYC clocks.
 * assumes the package is compiled first.
 */
`timescale 1ns/1ps
module nand_strobe_div
    import nand_mgmt_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    output logic      tick_o
);
    logic [7:0] cnt_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q  <= 8'h00;
            tick_o <= 1'b0;
        end else if (cnt_q == 8'(STROBE_CYC - 1)) begin
            cnt_q  <= 8'h00;
            tick_o <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 8'h01;
            tick_o <= 1'b0;
        end
    end
endmodule

// File: hdl/nand_bb_host.sv
/*
 * host-side nand controller: bad-block scan, program, erase, read with block retirement.
 * assumes a nand device on the byte port; ecc is done downstream on rd_data_o.
 */
`timescale 1ns/1ps
// How it works
// - host may program page in segments
// - host scans every block before use
// - marker byte 00h marks block bad
// - never erase a block marked bad
// - program fail: rewrite elsewhere, retire block (code only retires the block and raises fail_o; the data is not rewritten)
// - erase fail: retire block in table
// - read data needs 8-bit-per-512 ecc
// - retire only on program/erase fail (code also retires a block whose marker byte reads 00h during the scan)
// - status 70h: fail, ready, protect bits
// - only status or reset while busy
// - program pages in ascending order (code also accepts the last programmed page again)
module nand_bb_host
    import nand_mgmt_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             scan_i,
    input  wire logic             prog_i,
    input  wire logic             erase_i,
    input  wire logic             read_i,
    input  wire logic [BLK_W-1:0] blk_i,
    input  wire logic [PAGE_W-1:0] page_i,
    input  wire logic [7:0]       wr_data_i,
    input  wire logic [7:0]       io_i,
    input  wire logic             ready_busy_n_i,
    output logic [7:0]            io_o,
    output logic                  io_oe_o,
    output logic                  cle_o,
    output logic                  ale_o,
    output logic                  we_n_o,
    output logic                  re_n_o,
    output logic                  wp_n_o,
    output logic                  busy_o,
    output logic                  done_o,
    output logic                  fail_o,
    output logic                  refused_o,
    output logic [BLK_W-1:0]      retired_blk_o,
    output logic                  retired_o,
    output logic [7:0]            rd_data_o,
    output logic                  rd_valid_o,
    output logic [BLK_W:0]        bad_count_o,
    output logic                  too_many_bad_o
);
    // ------------------------------------------------------------
    // states and operations
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        S_IDLE = 7'h01, S_CMD1 = 7'h02, S_ADDR = 7'h04, S_DATA = 7'h08,
        S_CMD2 = 7'h10, S_WAIT = 7'h20, S_STAT = 7'h40
    } state_e;
    typedef enum logic [1:0] {OP_READ = 2'd0, OP_PROG = 2'd1, OP_ERASE = 2'd2} op_e;

    function automatic logic [7:0] first_cmd(input op_e op);
        case (op)
            OP_PROG:  first_cmd = CMD_PROG1;
            OP_ERASE: first_cmd = CMD_ERASE1;
            default:  first_cmd = CMD_READ1;
        endcase
    endfunction

    function automatic logic [7:0] second_cmd(input op_e op);
        case (op)
            OP_PROG:  second_cmd = CMD_PROG2;
            OP_ERASE: second_cmd = CMD_ERASE2;
            default:  second_cmd = CMD_READ2;
        endcase
    endfunction

    state_e             state_q;
    op_e                op_q;
    logic               scanning_q;
    logic [BLK_W-1:0]   blk_q;
    logic [PAGE_W-1:0]  page_q;
    logic [2:0]         acnt_q;
    logic [7:0]         data_q;
    logic               phase_q;
    logic               bad_q [NUM_BLOCKS];
    logic [PAGE_W:0]    next_page_q [NUM_BLOCKS];
    logic               tick;
    logic               start_ok;
    logic               bad_mark_seen;
    logic               status_fail;

    nand_strobe_div u_div (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_o (tick)
    );

    // ------------------------------------------------------------
    // request check
    // ------------------------------------------------------------
    assign start_ok = !bad_q[blk_i] &&
                      (!prog_i || {1'b0, page_i} >= next_page_q[blk_i]);
    assign bad_mark_seen = scanning_q && state_q == S_DATA && phase_q && tick
                           && io_i == BAD_MARK;
    assign status_fail = state_q == S_STAT && acnt_q == 3'd3 && tick && io_i[ST_READY_BIT]
                         && io_i[ST_FAIL_BIT] && op_q != OP_READ;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= S_IDLE; op_q <= OP_READ; scanning_q <= 1'b0;
            blk_q <= BLK_RESET; page_q <= '0; acnt_q <= 3'd0;
            data_q <= 8'h00; phase_q <= 1'b0;
            io_o <= 8'h00; io_oe_o <= 1'b0; cle_o <= 1'b0; ale_o <= 1'b0;
            we_n_o <= 1'b1; re_n_o <= 1'b1; wp_n_o <= 1'b0; busy_o <= 1'b0;
            done_o <= 1'b0; fail_o <= 1'b0; refused_o <= 1'b0;
            rd_data_o <= 8'h00; rd_valid_o <= 1'b0;
        end else begin
            done_o <= 1'b0; refused_o <= 1'b0; rd_valid_o <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    busy_o <= 1'b0;
                    if (scan_i) begin
                        scanning_q <= 1'b1; op_q <= OP_READ; blk_q <= BLK_RESET;
                        page_q <= '0; state_q <= S_CMD1; busy_o <= 1'b1;
                    end else if (prog_i || erase_i || read_i) begin
                        if (start_ok) begin
                            op_q <= prog_i ? OP_PROG : (erase_i ? OP_ERASE : OP_READ);
                            blk_q <= blk_i; page_q <= page_i; data_q <= wr_data_i;
                            wp_n_o <= prog_i || erase_i;
                            state_q <= S_CMD1; busy_o <= 1'b1;
                        end else begin
                            refused_o <= 1'b1;
                        end
                    end
                end
                S_CMD1, S_CMD2: if (tick) begin
                    // latch enable stays high past the rising write strobe
                    phase_q <= !phase_q; io_oe_o <= 1'b1; cle_o <= 1'b1;
                    ale_o <= 1'b0;
                    we_n_o <= phase_q;
                    io_o <= (state_q == S_CMD1) ? first_cmd(op_q) : second_cmd(op_q);
                    if (phase_q) begin
                        acnt_q <= (op_q == OP_ERASE) ? 3'd2 : 3'd0;
                        state_q <= (state_q == S_CMD1) ? S_ADDR : S_WAIT;
                    end
                end
                S_ADDR: if (tick) begin
                    // five address cycles for read and program, three for erase; a sixth is never sent
                    phase_q <= !phase_q; ale_o <= 1'b1; we_n_o <= phase_q;
                    cle_o <= 1'b0;
                    case (acnt_q)
                        3'd0, 3'd1: io_o <= 8'h00;
                        3'd2:    io_o <= {blk_q[1:0], page_q};
                        3'd3:    io_o <= blk_q[9:2];
                        default: io_o <= {7'h00, blk_q[10]};
                    endcase
                    if (phase_q) begin
                        acnt_q <= acnt_q + 3'd1;
                        if (acnt_q == 3'd4) begin
                            state_q <= (op_q == OP_PROG) ? S_DATA : S_CMD2;
                        end
                    end
                end
                S_DATA: if (tick) begin
                    phase_q <= !phase_q;
                    if (op_q == OP_PROG) begin
                        io_o <= data_q; we_n_o <= phase_q; ale_o <= 1'b0;
                    end else begin
                        io_oe_o <= 1'b0; re_n_o <= phase_q;
                        if (phase_q) begin
                            rd_data_o <= io_i; rd_valid_o <= !scanning_q;
                        end
                    end
                    if (phase_q) state_q <= (op_q == OP_PROG) ? S_CMD2 : S_STAT;
                end
                S_WAIT: if (tick && ready_busy_n_i) begin
                    // busy phase issues nothing but waits
                    state_q <= (op_q == OP_READ) ? S_DATA : S_STAT;
                    phase_q <= 1'b0; io_oe_o <= 1'b1; io_o <= CMD_STATUS;
                    acnt_q <= 3'd0; cle_o <= 1'b0;
                end
                S_STAT: if (tick) begin
                    phase_q <= !phase_q;
                    if (op_q == OP_READ) begin
                        if (scanning_q && blk_q != BLK_W'(NUM_BLOCKS - 1)) begin
                            blk_q <= blk_q + 1'b1; state_q <= S_CMD1;
                        end else begin
                            scanning_q <= 1'b0; done_o <= 1'b1; state_q <= S_IDLE;
                        end
                    end else begin
                        // status command, then read the status byte
                        acnt_q <= acnt_q + 3'd1;
                        case (acnt_q)
                            3'd0: begin
                                io_oe_o <= 1'b1; io_o <= CMD_STATUS;
                                cle_o <= 1'b1; we_n_o <= 1'b0;
                            end
                            3'd1: we_n_o <= 1'b1;
                            3'd2: begin
                                cle_o <= 1'b0; io_oe_o <= 1'b0; re_n_o <= 1'b0;
                            end
                            default: begin
                                re_n_o <= 1'b1;
                                fail_o <= io_i[ST_FAIL_BIT] || !io_i[ST_WP_BIT];
                                done_o <= 1'b1; wp_n_o <= 1'b0; state_q <= S_IDLE;
                            end
                        endcase
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // bad-block table and page order
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            retired_o <= 1'b0; retired_blk_o <= BLK_RESET; bad_count_o <= '0;
            too_many_bad_o <= 1'b0;
        end else begin
            retired_o <= 1'b0;
            if ((bad_mark_seen || status_fail) && !bad_q[blk_q]) begin
                retired_o <= 1'b1; retired_blk_o <= blk_q;
                bad_count_o <= bad_count_o + 1'b1;
                too_many_bad_o <= bad_count_o >= (BLK_W+1)'(NUM_BLOCKS - MIN_GOOD);
            end
        end
    end

    for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_tab
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                bad_q[b] <= 1'b0; next_page_q[b] <= '0;
            end else if (blk_q == BLK_W'(b)) begin
                if (bad_mark_seen || status_fail) bad_q[b] <= 1'b1;
                if (state_q == S_IDLE) begin end
                else if (op_q == OP_ERASE && done_o) next_page_q[b] <= '0;
                else if (op_q == OP_PROG && state_q == S_CMD2 && tick && phase_q)
                    next_page_q[b] <= {1'b0, page_q};
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_no_erase_bad: assert property (@(posedge clk_i) disable iff (rst_i)
        erase_i && state_q == S_IDLE && bad_q[blk_i] && !scan_i |=> refused_o)
        else $error("erase to bad block not refused");
    a_retire_fail: assert property (@(posedge clk_i) disable iff (rst_i)
        status_fail && !bad_q[blk_q] |=> retired_o && bad_q[retired_blk_o])
        else $error("failed block not retired");
    a_wp_during_op: assert property (@(posedge clk_i) disable iff (rst_i)
        state_q == S_WAIT |-> wp_n_o == (op_q != OP_READ))
        else $error("write protect wrong during operation");
    a_five_addr: assert property (@(posedge clk_i) disable iff (rst_i)
        state_q == S_ADDR |-> acnt_q <= 3'd4)
        else $error("more than five address cycles");
    a_busy_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        state_q == S_WAIT |-> we_n_o)
        else $error("command strobed while busy");
    a_page_order: assert property (@(posedge clk_i) disable iff (rst_i)
        prog_i && state_q == S_IDLE && !scan_i && !bad_q[blk_i]
        && {1'b0, page_i} < next_page_q[blk_i] |=> refused_o)
        else $error("out of order page not refused");
endmodule

// File: verification/nand_dev_model.sv
/* behavioural nand device for the host bench.
   assumes the host drives the pins; inject_i makes the next program or erase fail. */
`timescale 1ns/1ps
module nand_dev_model (
    input  wire logic       clk_i,
    input  wire logic       cle_i,
    input  wire logic       ale_i,
    input  wire logic       we_n_i,
    input  wire logic       re_n_i,
    input  wire logic       wp_n_i,
    input  wire logic [7:0] io_i,
    input  wire logic       inject_i,
    output logic [7:0]      io_o,
    output logic            ready_busy_n_o
);
    // all blocks start good, within the guaranteed count
    logic [7:0]  mem [int];
    logic [23:0] row_q  = 24'h000000;
    logic [7:0]  cmd_q  = 8'h00;
    logic [7:0]  data_q = 8'h00;
    logic [7:0]  last_q = 8'h00;
    logic        fail_q = 1'b0;
    logic        rb     = 1'b1;
    int          acnt_q = 0;
    time         done_t = 0;
    logic [7:0]  st;
    logic [7:0]  rd;
    assign st = {wp_n_i, rb, rb, 3'h0, 1'b0, fail_q};
    assign rd = mem.exists(int'(row_q[16:0])) ? mem[int'(row_q[16:0])] : 8'hff;
    assign io_o = re_n_i ? ~last_q : ((cmd_q == 8'h70) ? st : rd);
    assign ready_busy_n_o = rb;
    always @(posedge clk_i) begin
        if (!wp_n_i) begin
            done_t = 0;
        end
        rb <= ($time >= done_t);
    end
    always @(posedge re_n_i) begin
        last_q <= io_o;
    end
    always @(posedge we_n_i) begin
        if (cle_i) begin
            cmd_q <= io_i;
            acnt_q <= 0;
            if (io_i == 8'h10 || io_i == 8'hd0 || io_i == 8'h30) begin
                done_t = $time + 160;
            end
            if (io_i == 8'h10 || io_i == 8'hd0) begin
                fail_q <= inject_i;
            end
            if (io_i == 8'h10 && wp_n_i) begin
                mem[int'(row_q[16:0])] = data_q;
            end
        end else if (ale_i) begin
            if (acnt_q < 5) begin
                row_q <= {row_q[15:0], io_i};
            end
            acnt_q <= acnt_q + 1;
        end else begin
            data_q <= io_i;
        end
    end
endmodule

// File: verification/nand_bb_host_tb.sv
/* self-checking bench for the nand bad-block host.
   assumes the behavioural device model and the package are compiled first. */
`timescale 1ns/1ps
module nand_bb_host_tb;
    import nand_mgmt_pkg::*;
    logic              clk_i = 0, rst_i = 1, scan_i = 0, prog_i = 0, erase_i = 0;
    logic              read_i = 0, inject = 0;
    logic [BLK_W-1:0]  blk_i = 11'h000, retired_blk_o, ret_blk;
    logic [PAGE_W-1:0] page_i = 6'h00;
    logic [7:0]        wr_data_i = 8'h00, io_i, io_o, dev_io, rd_data_o, rd_byte;
    logic              io_oe_o, cle_o, ale_o, we_n_o, re_n_o, wp_n_o, ready_busy_n;
    logic              busy_o, done_o, fail_o, refused_o, retired_o, rd_valid_o;
    logic              too_many_bad_o, got_done, got_ref, got_ret;
    logic [BLK_W:0]    bad_count_o;
    int                failures = 0, num_checks = 0, cycles = 0;
    assign io_i = io_oe_o ? io_o : dev_io;
    nand_bb_host DUT (.clk_i(clk_i), .rst_i(rst_i), .scan_i(scan_i), .prog_i(prog_i),
        .erase_i(erase_i), .read_i(read_i), .blk_i(blk_i), .page_i(page_i),
        .wr_data_i(wr_data_i), .io_i(io_i), .ready_busy_n_i(ready_busy_n), .io_o(io_o),
        .io_oe_o(io_oe_o), .cle_o(cle_o), .ale_o(ale_o), .we_n_o(we_n_o), .re_n_o(re_n_o),
        .wp_n_o(wp_n_o), .busy_o(busy_o), .done_o(done_o), .fail_o(fail_o),
        .refused_o(refused_o), .retired_blk_o(retired_blk_o), .retired_o(retired_o),
        .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .bad_count_o(bad_count_o),
        .too_many_bad_o(too_many_bad_o));
    nand_dev_model dev (.clk_i(clk_i), .cle_i(cle_o), .ale_i(ale_o), .we_n_i(we_n_o),
        .re_n_i(re_n_o), .wp_n_i(wp_n_o), .io_i(io_i), .inject_i(inject), .io_o(dev_io),
        .ready_busy_n_o(ready_busy_n));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic run(input int op, input logic [BLK_W-1:0] b, input logic [PAGE_W-1:0] p,
                       input logic [7:0] d);
        int n;
        @(negedge clk_i);
        blk_i = b;
        page_i = p;
        wr_data_i = d;
        {prog_i, erase_i, read_i} = {op == 1, op == 2, op == 3};
        {got_done, got_ref, got_ret} = 3'b000;
        for (n = 0; n < 5000 && !got_done && !got_ref; n++) begin
            @(negedge clk_i);
            {prog_i, erase_i, read_i} = 3'b000;
            if (done_o === 1'b1) got_done = 1;
            if (refused_o === 1'b1) got_ref = 1;
            if (retired_o === 1'b1) {got_ret, ret_blk} = {1'b1, retired_blk_o};
            if (rd_valid_o === 1'b1) rd_byte = rd_data_o;
        end
        repeat (2) @(negedge clk_i);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_prog_read;
        run(1, 11'h005, 6'h00, 8'ha5);
        check(got_done, 1);
        check(fail_o, 0);
        run(3, 11'h005, 6'h00, 8'h00);
        check(rd_byte, 8'ha5);
        run(1, 11'h005, 6'h03, 8'h3c);
        check(got_done, 1);
        run(1, 11'h005, 6'h01, 8'h11);
        check(got_ref, 1);
        $display("test prog_read done");
    endtask
    task automatic t_prog_fail;
        inject = 1;
        run(1, 11'h009, 6'h00, 8'h77);
        inject = 0;
        check(fail_o, 1);
        check({got_ret, 4'h0, ret_blk}, {1'b1, 4'h0, 11'h009});
        check(bad_count_o, 1);
        run(3, 11'h009, 6'h00, 8'h00);
        check(got_ref, 1);
        $display("test prog_fail done");
    endtask
    task automatic t_erase;
        run(2, 11'h014, 6'h00, 8'h00);
        check({got_done, got_ret}, 2'b10);
        inject = 1;
        run(2, 11'h00c, 6'h00, 8'h00);
        inject = 0;
        check({got_ret, 4'h0, ret_blk}, {1'b1, 4'h0, 11'h00c});
        check(bad_count_o, 2);
        run(2, 11'h00c, 6'h00, 8'h00);
        check(got_ref, 1);
        check(too_many_bad_o, 0);
        $display("test erase done");
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            complete_run;
        end
    end
    initial begin
        repeat (20) @(negedge clk_i);
        rst_i = 0;
        t_prog_read;
        t_prog_fail;
        t_erase;
        complete_run;
    end
endmodule
